// ### smc_pkg.sv
package smc_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROTECTED_MEMORY_SUPPLY_OFF_US   = 1;
    localparam int PROTECTED_MEMORY_SUPPLY_OFF_CYC  = (PROTECTED_MEMORY_SUPPLY_OFF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] ALE_CYC = 2'h2;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_PART = 12'h004;
    localparam logic [11:0] ADDR_DTOP = 12'h008;
    localparam logic [11:0] ADDR_STAT = 12'h00c;

    localparam int CTRL_PM_BIT  = 0;
    localparam int CTRL_PES_BIT = 1;
    localparam int CTRL_WEN_BIT = 2;
    localparam logic [2:0]  CTRL_RESET = 3'h1;
    localparam logic [15:0] PART_RESET = 16'h8000;
    localparam logic [15:0] DTOP_RESET = 16'hffff;

    localparam int STAT_RST    = 0;
    localparam int STAT_BACKUP = 1;
    localparam int STAT_WARN   = 2;
    localparam int STAT_TAMPER = 3;
    localparam int STAT_LOADER = 4;
    localparam int STAT_LARGE  = 5;
    localparam int STAT_FAULT  = 6;

    localparam logic [7:0] WARN_VECTOR = 8'h2b;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SMC_RUN, SMC_UV_RESET, SMC_BACKUP} smc_pwr_e;

    typedef struct packed {
        logic        valid;
        logic        fetch;
        logic        write;
        logic [15:0] addr;
    } smc_mem_req_s;

    typedef struct packed {
        logic nvram_ce_n;
        logic rw_n;
        logic exp_sel;
        logic rtc_sel;
        logic fetch_fault;
    } smc_mem_sel_s;

    localparam smc_mem_sel_s SEL_IDLE = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

endpackage : smc_pkg

// ### smc_supervisor.sv
// Functional notes
// - High reset input holds device in reset
// - Reset input weakly pulled low internally
// - Loader entry falling edge starts bootstrap loader
// - Loader pin pulled up; grounded enters loader
// - Tamper high erases keys, cuts protected supply
// - Address latch strobe captures low address byte
// - Partition mode set maps full spaces
// - Partition mode clear splits one space
// - Large variant allows only non-partitioned map
// - Unmapped data goes to expanded bus
// - Never fetch code over expanded bus
// - Peripheral space select exposes real-time clock
// - Warning threshold raises vector 2Bh, runs on
// - Minimum threshold holds reset until recovery
// - Undervoltage reset idles chip enables, rw
// - Backup threshold switches to lithium cell
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module smc_supervisor
    import smc_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b0
)
(
    input  wire logic         clk,                // System clock
    input  wire logic         arst_n,             // Async reset, low active
    input  wire logic         reset_pin,          // Reset input, high active
    input  wire logic         loader_entry_pin,   // Loader entry, falling edge
    input  wire logic         tamper_erase_input, // Tamper erase, high active
    input  wire logic         below_warning,      // Supply under warning level
    input  wire logic         below_min,          // Supply under minimum level
    input  wire logic         below_backup,       // Supply under switchover level
    input  wire smc_mem_req_s mem_req,            // Core memory request
    input  wire logic         psel,               // APB select
    input  wire logic         penable,            // APB enable
    input  wire logic         pwrite,             // APB write
    input  wire logic [11:0]  paddr,              // APB address
    input  wire logic [31:0]  pwdata,             // APB write data
    output logic      [31:0]  prdata,             // APB read data
    output logic              pready,             // APB ready
    output logic              pslverr,            // APB error
    output logic              core_reset,         // Core held in reset
    output logic              reset_pulldown_en,  // Weak pull-down on reset pin
    output logic              loader_pullup_en,   // Weak pull-up on loader pin
    output logic              loader_start,       // Start loader pulse
    output logic              key_erase,          // Destroy keys and vector RAM
    output logic              protected_memory_supply_off,           // Protected supply removed
    output logic              warn_vec_valid,     // Warning interrupt pulse
    output logic      [7:0]   warn_vec,           // Warning vector address
    output logic              backup_mode,        // Running from lithium cell
    output smc_mem_sel_s      mem_sel,            // Memory decode result
    output logic              ale,                // Address latch strobe
    output logic      [7:0]   exp_addr_lo,        // Muxed port address byte
    output logic      [7:0]   exp_addr_hi         // High address port
);

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [2:0]   ctrl_ff;
    logic [15:0]  part_ff;
    logic [15:0]  dtop_ff;
    logic         warn_seen_ff;
    logic         tamper_seen_ff;
    logic         fault_seen_ff;
    logic         loader_seen_ff;
    smc_pwr_e     pwr_ff;
    logic         core_reset_ff;
    logic         wr_en;
    logic         rd_en;
    logic         hit;
    logic         pm_eff;
    logic         uv_hold;
    smc_mem_sel_s nxt_sel;

    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a == ADDR_CTRL) || (a == ADDR_PART) || (a == ADDR_DTOP) || (a == ADDR_STAT);
    endfunction : reg_hit

    assign hit     = reg_hit(paddr);
    assign wr_en   = psel && penable && pwrite && hit;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign pm_eff  = ctrl_ff[CTRL_PM_BIT] || LARGE_VARIANT;
    assign uv_hold = (pwr_ff != SMC_RUN);

    // Passive pulls: fixed in silicon, never released
    assign reset_pulldown_en = 1'b1;
    assign loader_pullup_en  = 1'b1;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            ctrl_ff <= CTRL_RESET;
            part_ff <= PART_RESET;
            dtop_ff <= DTOP_RESET;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                ADDR_CTRL:
                begin
                    // Large part ignores a request for partitioned mode
                    ctrl_ff[CTRL_PM_BIT]  <= pwdata[CTRL_PM_BIT] || LARGE_VARIANT;
                    ctrl_ff[CTRL_PES_BIT] <= pwdata[CTRL_PES_BIT];
                    ctrl_ff[CTRL_WEN_BIT] <= pwdata[CTRL_WEN_BIT];
                end
                ADDR_PART: part_ff <= pwdata[15:0];
                ADDR_DTOP: dtop_ff <= pwdata[15:0];
                default:   ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            prdata <= 32'h0;
        else if (rd_en)
        begin
            prdata <= 32'h0;
            unique case (paddr)
                ADDR_CTRL: prdata[2:0]  <= ctrl_ff;
                ADDR_PART: prdata[15:0] <= part_ff;
                ADDR_DTOP: prdata[15:0] <= dtop_ff;
                ADDR_STAT:
                begin
                    prdata[STAT_RST]    <= core_reset_ff;
                    prdata[STAT_BACKUP] <= (pwr_ff == SMC_BACKUP);
                    prdata[STAT_WARN]   <= warn_seen_ff;
                    prdata[STAT_TAMPER] <= tamper_seen_ff;
                    prdata[STAT_LOADER] <= loader_seen_ff;
                    prdata[STAT_LARGE]  <= LARGE_VARIANT;
                    prdata[STAT_FAULT]  <= fault_seen_ff;
                end
                default: prdata <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Power states and core reset
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            pwr_ff <= SMC_UV_RESET;
        else if (below_backup)
            pwr_ff <= SMC_BACKUP;
        else if (below_min)
            pwr_ff <= SMC_UV_RESET;
        else
            pwr_ff <= SMC_RUN;
    end

    // Level sensitive: released on the first clock the causes are gone
    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            core_reset_ff <= 1'b1;
        else
            core_reset_ff <= reset_pin || below_min || below_backup;
    end

    assign core_reset  = core_reset_ff;
    assign backup_mode = (pwr_ff == SMC_BACKUP);

    // ------------------------------------------------------------------
    // Bootstrap loader entry
    // ------------------------------------------------------------------
    logic loader_prev_ff;
    logic boot_done_ff;
    logic loader_ff;

    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            loader_prev_ff <= 1'b1;
            boot_done_ff   <= 1'b0;
            loader_ff      <= 1'b0;
        end
        else
        begin
            loader_prev_ff <= loader_entry_pin;
            boot_done_ff   <= 1'b1;
            // Strap check once after release, then edges only
            loader_ff <= (!boot_done_ff && !loader_entry_pin)
                      || (loader_prev_ff && !loader_entry_pin);
        end
    end

    assign loader_start = loader_ff;

    // ------------------------------------------------------------------
    // Tamper erase
    // ------------------------------------------------------------------
    logic        erase_ff;
    logic [15:0] protected_memory_supply_cnt_ff;

    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            erase_ff    <= 1'b0;
            protected_memory_supply_cnt_ff <= 16'h0;
        end
        else
        begin
            erase_ff <= tamper_erase_input;
            if (tamper_erase_input)
                protected_memory_supply_cnt_ff <= 16'(PROTECTED_MEMORY_SUPPLY_OFF_CYC);
            else if (protected_memory_supply_cnt_ff != 16'h0)
                protected_memory_supply_cnt_ff <= protected_memory_supply_cnt_ff - 16'h1;
        end
    end

    assign key_erase = erase_ff;
    assign protected_memory_supply_off  = (protected_memory_supply_cnt_ff != 16'h0);

    // ------------------------------------------------------------------
    // Power-fail warning
    // ------------------------------------------------------------------
    logic warn_prev_ff;
    logic warn_ff;

    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            warn_prev_ff <= 1'b0;
            warn_ff      <= 1'b0;
        end
        else
        begin
            warn_prev_ff <= below_warning;
            // Interrupt only; core keeps running
            warn_ff <= below_warning && !warn_prev_ff && ctrl_ff[CTRL_WEN_BIT];
        end
    end

    assign warn_vec_valid = warn_ff;
    assign warn_vec       = WARN_VECTOR;

    // ------------------------------------------------------------------
    // Sticky status, set wins over write-one-clear
    // ------------------------------------------------------------------
    logic stat_clr;
    assign stat_clr = wr_en && (paddr == ADDR_STAT);

    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            warn_seen_ff   <= 1'b0;
            tamper_seen_ff <= 1'b0;
            fault_seen_ff  <= 1'b0;
            loader_seen_ff <= 1'b0;
        end
        else
        begin
            warn_seen_ff   <= warn_ff || (warn_seen_ff && !(stat_clr && pwdata[STAT_WARN]));
            tamper_seen_ff <= erase_ff
                           || (tamper_seen_ff && !(stat_clr && pwdata[STAT_TAMPER]));
            fault_seen_ff  <= mem_sel.fetch_fault
                           || (fault_seen_ff && !(stat_clr && pwdata[STAT_FAULT]));
            loader_seen_ff <= loader_ff
                           || (loader_seen_ff && !(stat_clr && pwdata[STAT_LOADER]));
        end
    end

    // ------------------------------------------------------------------
    // Memory map decode
    // ------------------------------------------------------------------
    function automatic smc_mem_sel_s decode(input smc_mem_req_s r, input logic pm,
                                            input logic peripheral_space_select, input logic [15:0] part,
                                            input logic [15:0] dtop, input logic hold);
        smc_mem_sel_s s;
        s = SEL_IDLE;
        if (r.valid && !hold)
        begin
            if (r.fetch)
            begin
                if (pm || (r.addr < part))
                    s.nvram_ce_n = 1'b0;
                else
                    s.fetch_fault = 1'b1;
            end
            else if (peripheral_space_select)
                s.rtc_sel = 1'b1;
            else if (pm || ((r.addr >= part) && (r.addr <= dtop)))
            begin
                s.nvram_ce_n = 1'b0;
                s.rw_n       = !r.write;
            end
            else
                s.exp_sel = 1'b1;
        end
        decode = s;
    endfunction : decode

    assign nxt_sel = decode(mem_req, pm_eff, ctrl_ff[CTRL_PES_BIT], part_ff, dtop_ff,
                            uv_hold || core_reset_ff);

    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            mem_sel <= SEL_IDLE;
        else
            mem_sel <= nxt_sel;
    end

    // ------------------------------------------------------------------
    // Expanded bus address strobe
    // ------------------------------------------------------------------
    logic [1:0] ale_cnt_ff;

    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            ale_cnt_ff  <= 2'h0;
            exp_addr_lo <= 8'h0;
            exp_addr_hi <= 8'h0;
        end
        else if (nxt_sel.exp_sel)
        begin
            // Address is held while the strobe is high, latch takes it on fall
            ale_cnt_ff  <= ALE_CYC;
            exp_addr_lo <= mem_req.addr[7:0];
            exp_addr_hi <= mem_req.addr[15:8];
        end
        else if (ale_cnt_ff != 2'h0)
            ale_cnt_ff <= ale_cnt_ff - 2'h1;
    end

    assign ale = (ale_cnt_ff != 2'h0);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_ff);

    chk_reset_pin_hold: assert property (reset_pin |=> core_reset)
        else $error("reset pin high but core not in reset");
    // Sampled sync reset keeps the release edge out of the check
    chk_reset_release: assert property (rst_n_ff && !reset_pin && !below_min
        && !below_backup |=> !core_reset)
        else $error("core reset not released one clock after causes clear");
    chk_loader_edge: assert property (boot_done_ff && $fell(loader_entry_pin)
        |=> loader_start)
        else $error("loader falling edge missed");
    chk_loader_single: assert property (loader_start && boot_done_ff |=> !loader_start)
        else $error("loader start longer than one cycle");
    chk_tamper_erase: assert property (tamper_erase_input |=> key_erase && protected_memory_supply_off)
        else $error("tamper did not erase and cut supply");
    chk_protected_memory_supply_restore: assert property ($fell(tamper_erase_input) |-> ##[1:110] !protected_memory_supply_off)
        else $error("protected supply not restored");
    chk_fetch_internal: assert property (mem_sel.fetch_fault
        |-> mem_sel.nvram_ce_n && !mem_sel.exp_sel)
        else $error("off-board fetch reached a bus");
    chk_exp_ale: assert property (mem_sel.exp_sel |-> ale
        && (exp_addr_lo == $past(mem_req.addr[7:0])))
        else $error("expanded access without address strobe");
    chk_uv_idle: assert property (pwr_ff != SMC_RUN |=> mem_sel.nvram_ce_n && mem_sel.rw_n)
        else $error("chip enable active in undervoltage reset");
    chk_warn_vec: assert property ($rose(below_warning) && ctrl_ff[CTRL_WEN_BIT]
        |=> warn_vec_valid && warn_vec == WARN_VECTOR)
        else $error("warning vector not raised");
    chk_warn_off: assert property (!ctrl_ff[CTRL_WEN_BIT] |=> !warn_vec_valid)
        else $error("warning raised while disabled");
    chk_large_pm: assert property (LARGE_VARIANT |-> ctrl_ff[CTRL_PM_BIT])
        else $error("partitioned mode on large variant");
    chk_backup_mode: assert property (below_backup |=> backup_mode && core_reset)
        else $error("no switchover to backup");

endmodule : smc_supervisor

// ### smc_far_model.sv
`timescale 1ns/1ps
module smc_far_model
    import smc_pkg::*;
(
    input  wire logic       clk,                // System clock
    input  wire logic       loader_req,         // Ask for one loader entry
    input  wire logic       strap_low,          // Tie loader pin to ground
    input  wire logic       tamper_req,         // Tamper sensor tripped
    input  wire logic       ale,                // Address latch strobe
    input  wire logic [7:0] exp_addr_lo,        // Muxed port address byte
    output logic            loader_entry_pin,   // Loader entry pin level
    output logic            tamper_erase_input, // Tamper erase level
    output logic      [7:0] latched_lo          // External latch output
);
    logic [2:0] hold_ff = 3'h0;

    // ------------------------------------------------------------------
    // Loader host and tamper circuit
    // ------------------------------------------------------------------
    // Low time is stretched so a request never bounces into two edges
    always_ff @(posedge clk)
    begin
        if (loader_req)
            hold_ff <= 3'h4;
        else if (hold_ff != 3'h0)
            hold_ff <= hold_ff - 3'h1;
    end

    assign loader_entry_pin   = !(strap_low || hold_ff != 3'h0);
    assign tamper_erase_input = tamper_req;

    // ------------------------------------------------------------------
    // Transparent address latch on the muxed port
    // ------------------------------------------------------------------
    always_latch
    begin
        if (ale)
            latched_lo <= exp_addr_lo;
    end
endmodule : smc_far_model

// ### supervisor_and_memory_map_control_tb.sv
`timescale 1ns/1ps
module supervisor_and_memory_map_control_tb
    import smc_pkg::*;
;
    logic         clk = 1'b0;
    logic         arst_n = 1'b0;
    logic         reset_pin = 1'b0;
    logic         below_warning = 1'b0;
    logic         below_min = 1'b0;
    logic         below_backup = 1'b0;
    logic         loader_req = 1'b0;
    logic         strap_low = 1'b0;
    logic         tamper_req = 1'b0;
    smc_mem_req_s mem_req = '0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h0;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata;
    logic         pready, pslverr, core_reset, reset_pulldown_en, loader_pullup_en;
    logic         loader_start, key_erase, protected_memory_supply_off, warn_vec_valid, backup_mode, ale;
    logic [7:0]   warn_vec, exp_addr_lo, exp_addr_hi, latched_lo;
    smc_mem_sel_s mem_sel;
    logic         loader_entry_pin, tamper_erase_input;
    logic [31:0]  rd;
    logic         er;
    int           num_errors = 0;
    int           compares = 0;
    int           cycles = 0;
    int           n;

    always #5 clk = ~clk;

    smc_supervisor #(.LARGE_VARIANT(1'b0)) i_dut (
        .clk(clk), .arst_n(arst_n), .reset_pin(reset_pin),
        .loader_entry_pin(loader_entry_pin), .tamper_erase_input(tamper_erase_input),
        .below_warning(below_warning), .below_min(below_min), .below_backup(below_backup),
        .mem_req(mem_req), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_reset(core_reset), .reset_pulldown_en(reset_pulldown_en),
        .loader_pullup_en(loader_pullup_en), .loader_start(loader_start),
        .key_erase(key_erase), .protected_memory_supply_off(protected_memory_supply_off), .warn_vec_valid(warn_vec_valid),
        .warn_vec(warn_vec), .backup_mode(backup_mode), .mem_sel(mem_sel), .ale(ale),
        .exp_addr_lo(exp_addr_lo), .exp_addr_hi(exp_addr_hi));

    smc_far_model i_far (
        .clk(clk), .loader_req(loader_req), .strap_low(strap_low),
        .tamper_req(tamper_req), .ale(ale), .exp_addr_lo(exp_addr_lo),
        .loader_entry_pin(loader_entry_pin), .tamper_erase_input(tamper_erase_input),
        .latched_lo(latched_lo));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task results;
        if (num_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task mem(input logic f, input logic w, input logic [15:0] a);
        @(posedge clk);
        mem_req <= '{1'b1, f, w, a};
        @(posedge clk);
        mem_req <= '0;
        #1;
    endtask : mem

    // Counts high cycles, so a stuck or doubled pulse shows as a bad count
    task pulse(input int i, input logic [31:0] e);
        n = 0;
        repeat (8)
        begin
            step(1);
            if ((i == 0 ? loader_start : warn_vec_valid) === 1'b1)
                n++;
        end
        chk(32'(n), e);
    endtask : pulse

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_pins;
        chk(reset_pulldown_en, 32'h1);
        chk(loader_pullup_en, 32'h1);
        chk(core_reset, 32'h0);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk({er, pready, rd[29:0]}, 32'hc0000000);
        @(posedge clk) reset_pin <= 1'b1;
        step(1);
        chk(core_reset, 32'h1);
        mem(1'b0, 1'b0, 16'h1234);
        chk(32'(mem_sel), 32'(SEL_IDLE));
        @(posedge clk) reset_pin <= 1'b0;
        step(1);
        chk(core_reset, 32'h0);
        @(posedge clk) loader_req <= 1'b1;
        @(posedge clk) loader_req <= 1'b0;
        pulse(0, 32'h1);
        @(posedge clk) tamper_req <= 1'b1;
        step(2);
        chk({key_erase, protected_memory_supply_off}, 32'h3);
        @(posedge clk) tamper_req <= 1'b0;
        step(2);
        chk(key_erase, 32'h0);
        n = 0;
        while (protected_memory_supply_off === 1'b1 && n < 300)
        begin
            step(1);
            n++;
        end
        chk(32'(n + 2 >= PROTECTED_MEMORY_SUPPLY_OFF_CYC && n <= PROTECTED_MEMORY_SUPPLY_OFF_CYC), 32'h1);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd, 32'h18);
        apb(1'b1, ADDR_STAT, 32'h18);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd, 32'h0);
    endtask : t_pins

    task t_power;
        @(posedge clk) below_warning <= 1'b1;
        pulse(1, 32'h0);
        @(posedge clk) below_warning <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h5);
        @(posedge clk) below_warning <= 1'b1;
        pulse(1, 32'h1);
        chk({warn_vec, core_reset}, {23'h0, WARN_VECTOR, 1'b0});
        @(posedge clk) below_min <= 1'b1;
        step(6);
        chk(core_reset, 32'h1);
        mem(1'b0, 1'b1, 16'h0100);
        chk(32'(mem_sel), 32'(SEL_IDLE));
        @(posedge clk) below_min <= 1'b0;
        step(3);
        chk(core_reset, 32'h0);
        @(posedge clk) below_backup <= 1'b1;
        step(3);
        chk({backup_mode, core_reset}, 32'h3);
        @(posedge clk) below_backup <= 1'b0;
        below_warning <= 1'b0;
        step(3);
        chk(backup_mode, 32'h0);
    endtask : t_power

    task t_map;
        mem(1'b0, 1'b0, 16'h90a5);
        chk(32'(mem_sel), 32'h08);
        mem(1'b0, 1'b1, 16'h90a5);
        chk(32'(mem_sel), 32'h00);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_PART, 32'h4000);
        apb(1'b1, ADDR_DTOP, 32'h7fff);
        apb(1'b0, ADDR_PART, 32'h0);
        chk(rd, 32'h4000);
        mem(1'b0, 1'b0, 16'h90a5);
        chk(32'(mem_sel), 32'h1c);
        chk({ale, exp_addr_hi, exp_addr_lo}, 32'h190a5);
        step(1);
        chk({ale, latched_lo}, 32'h1a5);
        step(1);
        chk(ale, 32'h0);
        mem(1'b0, 1'b0, 16'h5000);
        chk(32'(mem_sel), 32'h08);
        mem(1'b1, 1'b0, 16'h3000);
        chk(32'(mem_sel), 32'h08);
        mem(1'b1, 1'b0, 16'h5000);
        chk({mem_sel.exp_sel, mem_sel.fetch_fault}, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h2);
        mem(1'b0, 1'b0, 16'h5000);
        chk({mem_sel.rtc_sel, mem_sel.exp_sel}, 32'h2);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd, 32'h44);
    endtask : t_map

    task t_strap;
        @(posedge clk);
        arst_n    <= 1'b0;
        strap_low <= 1'b1;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        pulse(0, 32'h1);
        @(posedge clk) strap_low <= 1'b0;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'(CTRL_RESET));
    endtask : t_strap

    // ------------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            results();
        end
    end

    initial
    begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        step(4);
        t_pins();
        t_power();
        t_map();
        t_strap();
        results();
    end
endmodule : supervisor_and_memory_map_control_tb
